// ==== hdl/sps_fifo.sv ====
// Byte FIFO with valid/ready on both sides and a pointer-only clear.
// Assumes one clock; clear, push and pop come from logic on that clock.
`timescale 1ns/100ps
module sps_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic                 clr_i,
  input  wire logic                 in_valid_i,
  output logic                      in_ready_o,
  input  wire logic [W-1:0]         in_data_i,
  output logic                      out_valid_o,
  input  wire logic                 out_ready_i,
  output logic [W-1:0]              out_data_o,
  output logic [$clog2(D):0]        level_o
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0]   cnt_r;

  wire push = in_valid_i & in_ready_o;
  wire pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = cnt_r != (AW+1)'(D);
  assign out_valid_o = cnt_r != '0;
  assign out_data_o  = mem[rptr_r];
  assign level_o     = cnt_r;

  // Storage is never cleared, so a clear only moves pointers
  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem[wptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && clr_i)) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end else if (ce_i) begin
      wptr_r <= push ? AW'(wptr_r + 1'b1) : wptr_r;
      rptr_r <= pop ? AW'(rptr_r + 1'b1) : rptr_r;
      cnt_r  <= (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end

endmodule : sps_fifo

// ==== hdl/sps_pkg.sv ====
// Shared constants, register map and types for the SPI slave FIFO block.
// Assumes a 100 MHz clk_i and a 32-bit classic Wishbone register bus.
package sps_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS         = 1000;
  localparam int CYC_PER_US    = US_NS / CLK_PERIOD_NS;
  localparam int PRESC_W       = 7;
  localparam logic [PRESC_W-1:0] PRESC_MAX = PRESC_W'(CYC_PER_US - 1);

  localparam int ADR_W = 6;
  localparam logic [ADR_W-1:0] OFS_CTRL   = 6'h00;
  localparam logic [ADR_W-1:0] OFS_FRST   = 6'h04;
  localparam logic [ADR_W-1:0] OFS_TXDATA = 6'h08;
  localparam logic [ADR_W-1:0] OFS_RXDATA = 6'h0C;
  localparam logic [ADR_W-1:0] OFS_TXLVL  = 6'h10;
  localparam logic [ADR_W-1:0] OFS_RXLVL  = 6'h14;
  localparam logic [ADR_W-1:0] OFS_STAT   = 6'h18;
  localparam logic [ADR_W-1:0] OFS_THR    = 6'h1C;
  localparam logic [ADR_W-1:0] OFS_TMO    = 6'h20;
  localparam logic [ADR_W-1:0] OFS_IEN    = 6'h24;
  localparam logic [ADR_W-1:0] OFS_IPEND  = 6'h28;

  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_LSB_BIT = 1;
  localparam int FRST_TX_BIT  = 0;
  localparam int FRST_RX_BIT  = 1;
  localparam int THR_TX_LSB   = 0;
  localparam int THR_RX_LSB   = 8;
  localparam int TMO_W        = 12;
  localparam int STAT_RX_NE   = 0;
  localparam int STAT_TX_NE   = 1;
  localparam int STAT_RX_OVER = 2;
  localparam int STAT_TX_OVER = 3;

  localparam int NIRQ          = 9;
  localparam int IRQ_RX_FIRST  = 0;
  localparam int IRQ_TX_LAST   = 1;
  localparam int IRQ_RX_RISE   = 2;
  localparam int IRQ_TX_FALL   = 3;
  localparam int IRQ_RX_OVF    = 4;
  localparam int IRQ_TX_OVF    = 5;
  localparam int IRQ_RX_UNF    = 6;
  localparam int IRQ_TX_UNF    = 7;
  localparam int IRQ_RX_TMO    = 8;

  localparam logic             CTRL_EN_RST  = 1'b0;
  localparam logic             CTRL_LSB_RST = 1'b0;
  localparam logic [7:0]       THR_RST      = 8'h00;
  localparam logic [TMO_W-1:0] TMO_RST      = 12'h000;
  localparam logic [NIRQ-1:0]  IEN_RST      = 9'h000;
  localparam logic [7:0]       TX_IDLE_BYTE = 8'hFF;

  typedef struct packed {
    logic [ADR_W-1:0] adr;
    logic             we;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } sps_wb_req_t;

  typedef enum logic [0:0] {
    SPS_IDLE = 1'b0,
    SPS_XFER = 1'b1
  } sps_shift_st_t;

  function automatic logic [31:0] sps_be_mask(input logic [3:0] sel);
    sps_be_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : sps_be_mask

endpackage : sps_pkg

// ==== hdl/sps_shift.sv ====
// Serial engine: mode 0 byte shifter driven by an external master.
// Assumes sck, select and mosi are already synchronised to clk_i.
`timescale 1ns/100ps
module sps_shift (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       en_i,
  input  wire logic       lsb_first_i,
  input  wire logic       sck_i,
  input  wire logic       sel_n_i,
  input  wire logic       mosi_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_pop_o,
  output logic            tx_under_o,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            miso_o,
  output logic            miso_oe_o
);
  sps_pkg::sps_shift_st_t st_r;
  logic       sck_d_r;
  logic [2:0] cnt_r;
  logic [7:0] txs_r;
  logic [7:0] rxs_r;

  wire       active = en_i & ~sel_n_i;
  wire       rise   = sck_i & ~sck_d_r;
  wire       fall   = ~sck_i & sck_d_r;
  wire       load   = (st_r == sps_pkg::SPS_IDLE) | (cnt_r == 3'h0);
  wire [7:0] ld     = tx_valid_i ? tx_data_i : sps_pkg::TX_IDLE_BYTE;
  wire [7:0] tx_sh  = lsb_first_i ? {1'b0, txs_r[7:1]} : {txs_r[6:0], 1'b0};
  wire [7:0] tx_nxt = load ? ld : tx_sh;
  wire       bit_nxt = lsb_first_i ? tx_nxt[0] : tx_nxt[7];
  wire [7:0] rx_nxt = lsb_first_i ? {mosi_i, rxs_r[7:1]} : {rxs_r[6:0], mosi_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r       <= sps_pkg::SPS_IDLE;
      sck_d_r    <= 1'b0;
      cnt_r      <= 3'h0;
      txs_r      <= 8'h00;
      rxs_r      <= 8'h00;
      miso_o     <= 1'b0;
      miso_oe_o  <= 1'b0;
      tx_pop_o   <= 1'b0;
      tx_under_o <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o  <= 8'h00;
    end else if (ce_i) begin
      sck_d_r    <= sck_i;
      tx_pop_o   <= 1'b0;
      tx_under_o <= 1'b0;
      rx_valid_o <= 1'b0;
      // [R01] Disabled slave idles
      if (!active) begin
        st_r      <= sps_pkg::SPS_IDLE;
        miso_oe_o <= 1'b0;
        cnt_r     <= 3'h0;
      end else begin
        case (st_r)
          sps_pkg::SPS_IDLE: begin
            // [R18] First bit ready before master clocks
            st_r       <= sps_pkg::SPS_XFER;
            miso_oe_o  <= 1'b1;
            txs_r      <= tx_nxt;
            miso_o     <= bit_nxt;
            tx_pop_o   <= tx_valid_i;
            tx_under_o <= ~tx_valid_i;
          end
          sps_pkg::SPS_XFER: begin
            if (rise) begin
              // [R13] Bit order select
              rxs_r <= rx_nxt;
              cnt_r <= 3'(cnt_r + 1'b1);
              if (cnt_r == 3'h7) begin
                rx_valid_o <= 1'b1;
                rx_data_o  <= rx_nxt;
              end
            end
            if (fall) begin
              txs_r  <= tx_nxt;
              miso_o <= bit_nxt;
              if (cnt_r == 3'h0) begin
                tx_pop_o   <= tx_valid_i;
                tx_under_o <= ~tx_valid_i;
              end
            end
          end
          default: st_r <= sps_pkg::SPS_IDLE;
        endcase
      end
    end
  end

endmodule : sps_shift

// ==== hdl/sps_top.sv ====
// SPI slave with transmit/receive byte FIFOs behind a Wishbone slave.
// Assumes an external SPI master (mode 0) and a classic Wishbone master.
//
// Behaviour
// [R01] Enable bit; when clear the slave ignores the link entirely.
// [R02] Separate reset requests for transmit and receive FIFO.
// [R03] FIFO reset zeroes pointers and fill count.
// [R04] FIFO reset leaves stored bytes untouched.
// [R05] Writing the transmit data port appends a byte.
// [R06] Reading the receive data port pops the oldest byte.
// [R07] Transmit fill level is readable.
// [R08] Receive fill level is readable.
// [R09] Status bit 0x1 set while receive FIFO not empty.
// [R10] Status bit 0x2 set while transmit FIFO not empty.
// [R11] Status bit 0x4 set while receive level above threshold.
// [R12] Status bit 0x8 set while transmit level above threshold.
// [R13] Configuration bit selects LSB-first or MSB-first bit order.
// [R14] Both thresholds programmable from 0 to 255 bytes.
// [R15] Receive timeout programmable 0 to 4095 microseconds.
// [R16] Nine maskable interrupt sources at enable bits 0 to 8.
// [R17] Interrupt output high while any enabled source pending.
// [R18] Master drives clock and select for a whole transfer.
`timescale 1ns/100ps
module sps_top #(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        spi_sck_i,
  input  wire logic        spi_sel_n_i,
  input  wire logic        spi_mosi_i,
  output logic             spi_miso_o,
  output logic             spi_miso_oe_o,
  output logic             irq_o
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // Pin synchronisers
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;

  // Bus side
  sps_pkg::sps_wb_req_t rq;
  logic                 ack_r;
  logic [31:0]          rdat_r;

  // Software state
  logic                      en_r;
  logic                      lsb_r;
  logic [7:0]                tx_thr_r;
  logic [7:0]                rx_thr_r;
  logic [sps_pkg::TMO_W-1:0] tmo_r;
  logic [sps_pkg::NIRQ-1:0]  ien_r;
  logic [sps_pkg::NIRQ-1:0]  pend_r;
  logic                      irq_r;

  // Event history
  logic rx_over_d_r;
  logic tx_over_d_r;

  // Timeout
  logic [sps_pkg::PRESC_W-1:0] presc_r;
  logic [sps_pkg::TMO_W-1:0]   us_r;
  logic                        fired_r;

  // FIFO and engine wires
  logic          tx_in_ready;
  logic          tx_out_valid;
  logic [7:0]    tx_out_data;
  logic [LW-1:0] tx_lvl;
  logic          rx_in_ready;
  logic          rx_out_valid;
  logic [7:0]    rx_out_data;
  logic [LW-1:0] rx_lvl;
  logic          sh_tx_pop;
  logic          sh_tx_under;
  logic          sh_rx_valid;
  logic [7:0]    sh_rx_data;

  assign rq = {wb_adr_i[sps_pkg::ADR_W-1:0], wb_we_i, wb_sel_i, wb_dat_i};

  // Decode
  wire        req       = wb_cyc_i & wb_stb_i & ~ack_r;
  wire        wr        = req & rq.we;
  wire        rd        = req & ~rq.we;
  wire [31:0] wmask     = sps_pkg::sps_be_mask(rq.sel);
  wire [31:0] wd        = rq.dat & wmask;
  wire        hit_ctrl  = rq.adr == sps_pkg::OFS_CTRL;
  wire        hit_frst  = rq.adr == sps_pkg::OFS_FRST;
  wire        hit_txd   = rq.adr == sps_pkg::OFS_TXDATA;
  wire        hit_rxd   = rq.adr == sps_pkg::OFS_RXDATA;
  wire        hit_txlvl = rq.adr == sps_pkg::OFS_TXLVL;
  wire        hit_rxlvl = rq.adr == sps_pkg::OFS_RXLVL;
  wire        hit_stat  = rq.adr == sps_pkg::OFS_STAT;
  wire        hit_thr   = rq.adr == sps_pkg::OFS_THR;
  wire        hit_tmo   = rq.adr == sps_pkg::OFS_TMO;
  wire        hit_ien   = rq.adr == sps_pkg::OFS_IEN;
  wire        hit_ipend = rq.adr == sps_pkg::OFS_IPEND;
  wire        upper_ok  = wb_adr_i[31:sps_pkg::ADR_W] == '0;

  // [R02] Independent FIFO reset requests
  wire tx_fifo_reset_req = wr & upper_ok & hit_frst & wd[sps_pkg::FRST_TX_BIT];
  wire rx_fifo_reset_req = wr & upper_ok & hit_frst & wd[sps_pkg::FRST_RX_BIT];

  // [R05] Byte write appends to transmit FIFO
  wire tx_push = wr & upper_ok & hit_txd & rq.sel[0];
  wire tx_ovf  = tx_push & ~tx_in_ready;

  // [R06] Read pops oldest receive byte
  wire rx_pop  = rd & upper_ok & hit_rxd;
  wire rx_unf  = rx_pop & ~rx_out_valid;

  wire rx_push = sh_rx_valid & rx_in_ready;
  wire rx_ovf  = sh_rx_valid & ~rx_in_ready;

  // [R09] Receive not empty
  wire stat_rx_nonempty = rx_lvl != '0;
  // [R10] Transmit not empty
  wire stat_tx_nonempty = tx_lvl != '0;
  // [R11] Receive above threshold
  wire stat_rx_over_threshold = 8'(rx_lvl) > rx_thr_r;
  // [R12] Transmit above threshold
  wire stat_tx_over_threshold = 8'(tx_lvl) > tx_thr_r;

  wire [3:0] status = {stat_tx_over_threshold, stat_rx_over_threshold,
                       stat_tx_nonempty, stat_rx_nonempty};

  // [R15] Timeout of zero disables the event
  wire tmo_hit = stat_rx_nonempty & ~fired_r & (tmo_r != '0) & (us_r == tmo_r);
  wire tmo_rst = rx_push | rx_pop | ~stat_rx_nonempty | rx_fifo_reset_req;
  wire us_tick = presc_r == sps_pkg::PRESC_MAX;

  // [R16] Interrupt source events
  wire irq_rx_first_byte     = rx_push & ~stat_rx_nonempty;
  wire irq_tx_last_byte      = sh_tx_pop & (tx_lvl == LW'(1));
  wire irq_rx_rise_threshold = stat_rx_over_threshold & ~rx_over_d_r;
  wire irq_tx_fall_threshold = ~stat_tx_over_threshold & tx_over_d_r;
  wire irq_rx_overflow       = rx_ovf;
  wire irq_tx_overflow       = tx_ovf;
  wire irq_rx_underflow      = rx_unf;
  wire irq_tx_underflow      = sh_tx_under;
  wire irq_rx_timeout        = tmo_hit;

  wire [sps_pkg::NIRQ-1:0] events = {irq_rx_timeout, irq_tx_underflow,
                                     irq_rx_underflow, irq_tx_overflow,
                                     irq_rx_overflow, irq_tx_fall_threshold,
                                     irq_rx_rise_threshold, irq_tx_last_byte,
                                     irq_rx_first_byte};

  // Write one to clear; a new event in the same cycle survives
  wire [sps_pkg::NIRQ-1:0] pend_clr = (wr & upper_ok & hit_ipend) ? wd[sps_pkg::NIRQ-1:0] : '0;
  wire [sps_pkg::NIRQ-1:0] pend_nxt = (pend_r & ~pend_clr) | events;

  wire ctrl_we = wr & upper_ok & hit_ctrl & rq.sel[0];
  wire thr_we  = wr & upper_ok & hit_thr;
  wire tmo_we  = wr & upper_ok & hit_tmo;
  wire ien_we  = wr & upper_ok & hit_ien;

  // [R14] Thresholds are full bytes
  wire [7:0] tx_thr_nxt = rq.sel[0] ? rq.dat[sps_pkg::THR_TX_LSB +: 8] : tx_thr_r;
  wire [7:0] rx_thr_nxt = rq.sel[1] ? rq.dat[sps_pkg::THR_RX_LSB +: 8] : rx_thr_r;

  wire [31:0] tmo_full = ({20'h00000, tmo_r} & ~wmask) | wd;
  wire [31:0] ien_full = ({23'h000000, ien_r} & ~wmask) | wd;

  // [R07] Transmit level readback
  // [R08] Receive level readback
  wire [31:0] rdat_nxt =
      ~upper_ok ? 32'h00000000 :
      hit_ctrl  ? {30'h00000000, lsb_r, en_r} :
      hit_rxd   ? (rx_out_valid ? {24'h000000, rx_out_data} : 32'h00000000) :
      hit_txlvl ? 32'(tx_lvl) :
      hit_rxlvl ? 32'(rx_lvl) :
      hit_stat  ? {28'h0000000, status} :
      hit_thr   ? {16'h0000, rx_thr_r, tx_thr_r} :
      hit_tmo   ? {20'h00000, tmo_r} :
      hit_ien   ? {23'h000000, ien_r} :
      hit_ipend ? {23'h000000, pend_r} :
      32'h00000000;

  // Pins cross into clk_i through two stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 3'h1;
      sync2_r <= 3'h1;
    end else if (ce_i) begin
      sync1_r <= {spi_mosi_i, spi_sck_i, spi_sel_n_i};
      sync2_r <= sync1_r;
    end
  end

  // Single-cycle answer; unmapped words read zero and still ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h00000000;
    end else if (ce_i) begin
      ack_r  <= req;
      rdat_r <= rd ? rdat_nxt : 32'h00000000;
    end
  end

  // [R01] Enable and bit order control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_r  <= sps_pkg::CTRL_EN_RST;
      lsb_r <= sps_pkg::CTRL_LSB_RST;
    end else if (ce_i && ctrl_we) begin
      en_r  <= rq.dat[sps_pkg::CTRL_EN_BIT];
      lsb_r <= rq.dat[sps_pkg::CTRL_LSB_BIT];
    end
  end

  // [R14] Threshold registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_thr_r <= sps_pkg::THR_RST;
      rx_thr_r <= sps_pkg::THR_RST;
    end else if (ce_i && thr_we) begin
      tx_thr_r <= tx_thr_nxt;
      rx_thr_r <= rx_thr_nxt;
    end
  end

  // [R15] Timeout and [R16] enable registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmo_r <= sps_pkg::TMO_RST;
      ien_r <= sps_pkg::IEN_RST;
    end else if (ce_i) begin
      tmo_r <= tmo_we ? tmo_full[sps_pkg::TMO_W-1:0] : tmo_r;
      ien_r <= ien_we ? ien_full[sps_pkg::NIRQ-1:0] : ien_r;
    end
  end

  // [R17] Sticky pending and masked output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r      <= '0;
      irq_r       <= 1'b0;
      rx_over_d_r <= 1'b0;
      tx_over_d_r <= 1'b0;
    end else if (ce_i) begin
      pend_r      <= pend_nxt;
      irq_r       <= |(pend_nxt & ien_r);
      rx_over_d_r <= stat_rx_over_threshold;
      tx_over_d_r <= stat_tx_over_threshold;
    end
  end

  // [R15] Microsecond timer on waiting receive data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_r <= '0;
      us_r    <= '0;
      fired_r <= 1'b0;
    end else if (ce_i) begin
      if (tmo_rst) begin
        presc_r <= '0;
        us_r    <= '0;
        fired_r <= 1'b0;
      end else if (tmo_hit) begin
        fired_r <= 1'b1;
      end else if (!fired_r) begin
        presc_r <= us_tick ? '0 : sps_pkg::PRESC_W'(presc_r + 1'b1);
        us_r    <= us_tick ? sps_pkg::TMO_W'(us_r + 1'b1) : us_r;
      end
    end
  end

  // [R03] [R04] Clear moves pointers only
  sps_fifo #(
    .W (8),
    .D (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .clr_i       (tx_fifo_reset_req),
    .in_valid_i  (tx_push),
    .in_ready_o  (tx_in_ready),
    .in_data_i   (rq.dat[7:0]),
    .out_valid_o (tx_out_valid),
    .out_ready_i (sh_tx_pop),
    .out_data_o  (tx_out_data),
    .level_o     (tx_lvl)
  );

  // Full receive FIFO drops the byte; software sees the overflow
  sps_fifo #(
    .W (8),
    .D (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .clr_i       (rx_fifo_reset_req),
    .in_valid_i  (sh_rx_valid),
    .in_ready_o  (rx_in_ready),
    .in_data_i   (sh_rx_data),
    .out_valid_o (rx_out_valid),
    .out_ready_i (rx_pop),
    .out_data_o  (rx_out_data),
    .level_o     (rx_lvl)
  );

  // [R18] Engine follows the master clock and select
  // Changing bit order mid-byte corrupts that byte
  sps_shift u_shift (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .en_i        (en_r),
    .lsb_first_i (lsb_r),
    .sck_i       (sync2_r[1]),
    .sel_n_i     (sync2_r[0]),
    .mosi_i      (sync2_r[2]),
    .tx_valid_i  (tx_out_valid),
    .tx_data_i   (tx_out_data),
    .tx_pop_o    (sh_tx_pop),
    .tx_under_o  (sh_tx_under),
    .rx_valid_o  (sh_rx_valid),
    .rx_data_o   (sh_rx_data),
    .miso_o      (spi_miso_o),
    .miso_oe_o   (spi_miso_oe_o)
  );

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign irq_o    = irq_r;

endmodule : sps_top

// ==== testbench/sps_spi_master.sv ====
// Behavioural mode 0 SPI master, one byte per frame.
// Assumes clk_i is the slave's clock; all changes follow its rising edge.
`timescale 1ns/100ps
module sps_spi_master #(
  parameter int HALF = 5
) (
  input  wire logic clk_i,
  input  wire logic miso_i,
  output logic      sck_o,
  output logic      sel_n_o,
  output logic      mosi_o
);
  initial begin
    sck_o = 1'b0;
    sel_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic xfer(input logic [7:0] tx, input logic lsb, output logic [7:0] rx);
    int k;
    @(posedge clk_i);
    sel_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      k = lsb ? i : 7 - i;
      mosi_o <= tx[k];
      repeat (HALF) @(posedge clk_i);
      sck_o <= 1'b1;
      rx[k] = miso_i;
      repeat (HALF) @(posedge clk_i);
      // Last fall after deselect, so no extra byte is fetched
      if (i < 7) sck_o <= 1'b0;
    end
    sel_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    @(posedge clk_i);
    sck_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
  endtask : xfer
endmodule : sps_spi_master

// ==== testbench/sps_top_asserts.sv ====
// Port-level checker for the SPI slave FIFO block.
// Assumes a classic Wishbone master with one request open at a time.
`timescale 1ns/100ps
module sps_top_asserts #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        spi_sck_i,
  input wire logic        spi_sel_n_i,
  input wire logic        spi_mosi_i,
  input wire logic        spi_miso_o,
  input wire logic        spi_miso_oe_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  chk_ack_answer:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o) else $error("request not answered");
  chk_ack_cause:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  chk_idle_data_zero:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  chk_level_range:
    assert property (wb_ack_o && $past(!wb_we_i && (wb_adr_i == 32'h10 || wb_adr_i == 32'h14))
      |-> wb_dat_o <= 32'(FIFO_DEPTH)) else $error("level above depth");
  chk_status_bits:
    assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 32'h18) |-> wb_dat_o[31:4] == 28'h0)
      else $error("status has extra bits");
  chk_thr_width:
    assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 32'h1C) |-> wb_dat_o[31:16] == 16'h0)
      else $error("threshold wider than a byte");
  chk_tmo_width:
    assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 32'h20) |-> wb_dat_o[31:12] == 20'h0)
      else $error("timeout wider than 12 bits");
  chk_ien_width:
    assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 32'h24) |-> wb_dat_o[31:9] == 23'h0)
      else $error("more than nine enables");
  chk_oe_deselect:
    assert property (spi_sel_n_i [*4] |=> !spi_miso_oe_o) else $error("miso driven while deselected");
  chk_irq_reset:
    assert property ($fell(rst_i) |-> !irq_o) else $error("irq high after reset");
  cover property (wb_ack_o && $past(wb_we_i && wb_adr_i == 32'h08));
  cover property ($rose(irq_o));
  cover property ($rose(spi_miso_oe_o));
endmodule : sps_top_asserts

bind sps_top sps_top_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) i_sps_top_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .spi_sck_i(spi_sck_i), .spi_sel_n_i(spi_sel_n_i),
  .spi_mosi_i(spi_mosi_i), .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o), .irq_o(irq_o));

// ==== testbench/sps_top_test.sv ====
// Self-checking bench for the SPI slave FIFO block.
// Assumes the checker is bound to sps_top; clock enable stays high.
`timescale 1ns/100ps
module sps_top_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [31:0] adr   = 32'h0;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic [31:0] q;
  logic [7:0]  rx;
  logic        ack, sck, sel_n, mosi, miso, miso_oe, irq;
  logic        miso_last = 1'b0;
  wire logic   miso_line;
  int          error_cnt = 0;
  int          checks    = 0;
  always #5 clk_i = ~clk_i;
  // Released line shows the inverse of its last level
  always @(posedge clk_i) if (miso_oe) miso_last <= miso;
  assign miso_line = miso_oe ? miso : ~miso_last;
  sps_top #(.FIFO_DEPTH(32)) i_sps_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .spi_sck_i(sck), .spi_sel_n_i(sel_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .irq_o(irq));
  sps_spi_master i_sps_spi_master (.clk_i(clk_i), .miso_i(miso_line), .sck_o(sck),
    .sel_n_o(sel_n), .mosi_o(mosi));
  task automatic final_report;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(name, q, exp);
  endtask : rd
  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("ctrl", 32'h00, 32'h0);
    rd("stat", 32'h18, 32'h0);
    rd("unmapped", 32'h40, 32'h0);
    wb(1'b1, 32'h1C, 32'h0102);
    rd("thr", 32'h1C, 32'h0102);
    wb(1'b1, 32'h20, 32'hFFFFF);
    rd("tmo", 32'h20, 32'hFFF);
    wb(1'b1, 32'h24, 32'hFFFF);
    rd("ien", 32'h24, 32'h1FF);
    wb(1'b1, 32'h24, 32'h040);
    rd("rx_empty", 32'h0C, 32'h0);
    @(posedge clk_i);
    chk("irq_on", {31'h0, irq}, 32'h1);
    wb(1'b1, 32'h28, 32'h040);
    @(posedge clk_i);
    chk("irq_off", {31'h0, irq}, 32'h0);
    wb(1'b1, 32'h24, 32'h0);
    rd("rx_empty", 32'h0C, 32'h0);
    rd("ipend", 32'h28, 32'h040);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wb(1'b1, 32'h28, 32'h1FF);
    for (int i = 0; i < 33; i++) wb(1'b1, 32'h08, 32'h10 + i);
    rd("txlvl", 32'h10, 32'h20);
    rd("stat", 32'h18, 32'hA);
    rd("ipend", 32'h28, 32'h020);
    wb(1'b1, 32'h28, 32'h1FF);
    for (int i = 0; i < 32; i++) begin
      wb(1'b1, 32'h00, {30'h0, i[0], 1'b1});
      i_sps_spi_master.xfer(8'h80 + 8'(i), i[0], rx);
      chk("miso_byte", {24'h0, rx}, 32'h10 + i);
    end
    rd("txlvl", 32'h10, 32'h0);
    rd("rxlvl", 32'h14, 32'h20);
    rd("stat", 32'h18, 32'h5);
    wb(1'b0, 32'h28, 32'h0);
    chk("ipend_flow", q & 32'h17F, 32'h00F);
    wb(1'b1, 32'h00, 32'h1);
    i_sps_spi_master.xfer(8'h55, 1'b0, rx);
    chk("idle_byte", {24'h0, rx}, 32'hFF);
    wb(1'b0, 32'h28, 32'h0);
    chk("ipend_ovf", q & 32'h090, 32'h090);
    for (int i = 0; i < 31; i++) rd("rx_byte", 32'h0C, 32'h80 + i);
    rd("rxlvl", 32'h14, 32'h1);
    // One microsecond limit with a byte left waiting
    wb(1'b1, 32'h20, 32'h1);
    repeat (150) @(posedge clk_i);
    wb(1'b0, 32'h28, 32'h0);
    chk("ipend_tmo", q & 32'h100, 32'h100);
    wb(1'b1, 32'h08, 32'h33);
    wb(1'b1, 32'h08, 32'h44);
    wb(1'b1, 32'h04, 32'h1);
    rd("txlvl", 32'h10, 32'h0);
    rd("rxlvl", 32'h14, 32'h1);
    wb(1'b1, 32'h04, 32'h2);
    rd("rxlvl", 32'h14, 32'h0);
    rd("stat", 32'h18, 32'h0);
    wb(1'b1, 32'h00, 32'h0);
    i_sps_spi_master.xfer(8'h5A, 1'b0, rx);
    rd("rxlvl_off", 32'h14, 32'h0);
    final_report();
  end
endmodule : sps_top_test
